// File: design/sls_led_seq.sv
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
// Contract
// - After USB connect, blink green slowly until host recognizes device.
// - Once recognized, green on, briefly off on USB traffic.
// - In USB suspend on USB power, pulse green briefly once a second.
// - Red indicator equals the error output pin.
// - Energized, positive velocity: yellow fades in 0.5 s, holds full 0.5 s.
// - Energized, negative velocity: yellow fades out 0.5 s, holds full 0.5 s.
// - Energized, stopped, no error: yellow steady full.
// - Energized with non safe-start error: yellow on, blinks off twice.
// - Energized, only safe-start error: yellow on, blinks off once.
// - De-energized by driver fault: yellow blinks 8 times per second.
// - De-energized, supply low: yellow 0.5 s on, 0.5 s off.
// - Released by command: yellow mostly off, groups of three blinks.
// - De-energized, non safe-start error: yellow off, groups of two blinks.
// - De-energized, only safe-start error: yellow off, single blink.
// - New yellow pattern starts only after current one completes.
// - Yellow derives from driver drive signals only, no motor feedback.
// - After abnormal reset, yellow blinks eight times in one second, red lit.
// - During startup blinking ignore commands, skip inputs, coils off.
// - Bootloader recognized: green double blink every 1.4 s.
// - Bootloader: yellow solid, quick blink on each USB command.
// - Bootloader: red lit exactly when no application image present.
module sls_led_seq
  import sls_pkg::*;
#(
   parameter int TICK_CYCLES = sls_pkg::TICK_CYC
)(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire sls_pkg::sls_status_t sts,
   input  wire logic               reset_abnormal,
   output sls_pkg::sls_leds_t      leds,
   output logic                    err_out,
   output logic                    startup_busy,
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest
);

   // ------------------------------------------------------------
   // Millisecond time base
   // ------------------------------------------------------------
   logic [17:0] pre_q;
   logic        ms_tick;

   assign ms_tick = (pre_q == 18'(TICK_CYCLES - 1));

   // Prescaler from clock to 1 ms
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_q <= 18'h0;
      end else if (ce) begin
         pre_q <= ms_tick ? 18'h0 : pre_q + 18'h1;
      end
   end

   // ------------------------------------------------------------
   // Yellow frame timing
   // ------------------------------------------------------------
   logic [9:0] frame_q;
   logic [6:0] fast_q;
   logic [7:0] pwm_q;
   logic       frame_end;

   assign frame_end = ms_tick && (frame_q == 10'(FRAME_MS - 1));

   // Frame and 8 Hz sub-counters restart together so groups stay aligned
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frame_q <= 10'h0;
         fast_q  <= 7'h0;
      end else if (ce && ms_tick) begin
         frame_q <= frame_end ? 10'h0 : frame_q + 10'h1;
         fast_q  <= (frame_end || fast_q == 7'(FAST_MS - 1)) ? 7'h0 : fast_q + 7'h1;
      end
   end

   // PWM carrier, one full sweep every PWM_STEPS clock cycles
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwm_q <= 8'h0;
      end else if (ce) begin
         pwm_q <= (pwm_q == 8'(PWM_STEPS - 1)) ? 8'h0 : pwm_q + 8'h1;
      end
   end

   // ------------------------------------------------------------
   // Startup blinking after abnormal reset
   // ------------------------------------------------------------
   logic chk_q;
   logic startup_q;

   // Reset cause is caught by a clocked sample right after release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chk_q     <= 1'b1;
         startup_q <= 1'b0;
      end else if (ce) begin
         if (chk_q) begin
            chk_q     <= 1'b0;
            startup_q <= reset_abnormal;
         end else if (frame_end) begin
            startup_q <= 1'b0;
         end
      end
   end

   // Holds coils off and tells the core to drop commands and inputs
   assign startup_busy = startup_q | chk_q;

   // ------------------------------------------------------------
   // Yellow pattern selection
   // ------------------------------------------------------------
   sls_ypat_t ysel;
   sls_ypat_t ypat_q;

   // Only drive-side status is used; nothing from the motor itself
   always_comb begin
      ysel = Y_OFF;
      if (sts.coils_energized) begin
         if (sts.vel_pos) begin
            ysel = Y_FADE_UP;
         end else if (sts.vel_neg) begin
            ysel = Y_FADE_DN;
         end else if (sts.err_active && sts.safe_start_only) begin
            ysel = Y_ON_BLINK1;
         end else if (sts.err_active) begin
            ysel = Y_ON_BLINK2;
         end else begin
            ysel = Y_SOLID;
         end
      end else if (sts.driver_fault) begin
         ysel = Y_FAST8;
      end else if (sts.motor_supply_input_low) begin
         ysel = Y_SLOW;
      end else if (sts.coil_release_cmd) begin
         ysel = Y_OFF_BLINK3;
      end else if (sts.err_active && !sts.safe_start_only) begin
         ysel = Y_OFF_BLINK2;
      end else if (sts.err_active) begin
         ysel = Y_OFF_BLINK1;
      end
   end

   // Pattern swaps only at a frame boundary, so none is cut short
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ypat_q <= Y_OFF;
      end else if (ce && frame_end) begin
         ypat_q <= startup_busy ? Y_OFF : ysel;
      end
   end

   // True inside the first n slots of the frame during a slot's lit part
   function automatic logic grp_on(input logic [9:0] ms, input int n);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < 3; k++) begin
         if (k < n && ms >= 10'(k * SLOT_MS) && ms < 10'(k * SLOT_MS + SLOT_ON_MS)) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : grp_on

   logic [7:0] duty;
   logic       fast_on;
   logic       y_norm;

   // Duty rises one step per 2 ms across the ramp
   assign duty    = 8'(frame_q >> 1);
   assign fast_on = (fast_q < 7'(FAST_ON_MS));

   always_comb begin
      case (ypat_q)
         Y_OFF:        y_norm = 1'b0;
         Y_SOLID:      y_norm = 1'b1;
         Y_FADE_UP:    y_norm = (frame_q >= 10'(HALF_MS)) || (pwm_q < duty);
         Y_FADE_DN:    y_norm = (frame_q >= 10'(HALF_MS)) ||
                                (pwm_q < 8'(PWM_STEPS) - duty);
         Y_ON_BLINK2:  y_norm = !grp_on(frame_q, 2);
         Y_ON_BLINK1:  y_norm = !grp_on(frame_q, 1);
         Y_FAST8:      y_norm = fast_on;
         Y_SLOW:       y_norm = (frame_q < 10'(HALF_MS));
         Y_OFF_BLINK3: y_norm = grp_on(frame_q, 3);
         Y_OFF_BLINK2: y_norm = grp_on(frame_q, 2);
         Y_OFF_BLINK1: y_norm = grp_on(frame_q, 1);
         default:      y_norm = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Green timing and activity flicker
   // ------------------------------------------------------------
   logic [10:0] gms_q;
   logic        g_end;
   logic [5:0]  flick_q;
   logic [5:0]  cmd_q;

   assign g_end = ms_tick && (gms_q == (sts.boot_mode ? 11'(BOOT_FRAME_MS - 1)
                                                      : 11'(FRAME_MS - 1)));

   // Green period is 1.4 s in bootloader, 1 s otherwise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gms_q <= 11'h0;
      end else if (ce && ms_tick) begin
         gms_q <= g_end ? 11'h0 : gms_q + 11'h1;
      end
   end

   // A new event restarts the flicker, so a burst reads as one dark gap
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flick_q <= 6'h0;
      end else if (ce) begin
         if (sts.usb_activity) begin
            flick_q <= 6'(FLICK_MS);
         end else if (ms_tick && flick_q != 6'h0) begin
            flick_q <= flick_q - 6'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmd_q <= 6'h0;
      end else if (ce) begin
         if (sts.usb_cmd_rx) begin
            cmd_q <= 6'(FLICK_MS);
         end else if (ms_tick && cmd_q != 6'h0) begin
            cmd_q <= cmd_q - 6'h1;
         end
      end
   end

   logic g_raw;

   always_comb begin
      if (sts.usb_suspend && sts.usb_power_only) begin
         g_raw = (gms_q < 11'(SUSP_ON_MS));
      end else if (sts.boot_mode && sts.boot_recognized) begin
         g_raw = (gms_q < 11'(SLOT_ON_MS)) ||
                 (gms_q >= 11'(SLOT_MS) && gms_q < 11'(SLOT_MS + SLOT_ON_MS));
      end else if (sts.boot_mode || !sts.usb_configured) begin
         g_raw = (gms_q < 11'(HALF_MS));
      end else begin
         g_raw = (flick_q == 6'h0);
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic        ctrl_en_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        req;

   assign req             = avs_read || avs_write;
   assign avs_waitrequest = req && !ack_q; // One wait state on every access
   assign avs_readdata    = rdata_q;

   // Each access is answered on the edge after it is first seen
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else if (ce) begin
         ack_q <= req && !ack_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_en_q <= CTRL_EN_RST;
      end else if (ce && avs_write && ack_q && avs_address == CTRL_OFS &&
                   avs_byteenable[0]) begin
         ctrl_en_q <= avs_writedata[CTRL_EN_BIT];
      end
   end

   // Read data captured while waitrequest is high; unmapped reads zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0;
      end else if (ce && avs_read && !ack_q) begin
         rdata_q <= 32'h0;
         case (avs_address)
            CTRL_OFS: rdata_q[CTRL_EN_BIT] <= ctrl_en_q;
            STATUS_OFS: begin
               rdata_q[10:0]                    <= ypat_q;
               rdata_q[ST_BUSY_BIT]             <= startup_busy;
               rdata_q[ST_LED_LSB +: 3]         <= leds;
            end
            FRAME_OFS:  rdata_q[9:0] <= frame_q;
            default:    rdata_q <= 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic err_q;
   logic red_d;
   logic yel_d;

   // Error pin and red share one source; startup forces it lit unless in bootloader
   always_comb begin
      if (sts.boot_mode) begin
         red_d = !sts.app_image_present;
         yel_d = (cmd_q == 6'h0);
      end else if (startup_busy) begin
         red_d = 1'b1;
         yel_d = fast_on;
      end else begin
         red_d = sts.err_active;
         yel_d = y_norm;
      end
   end

   // LEDs come from flops; the enable blanks green and yellow but not red or the error pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_q  <= 1'b0;
         leds   <= '0;
      end else if (ce) begin
         err_q       <= red_d;
         leds.red    <= red_d;
         leds.green  <= ctrl_en_q && g_raw;
         leds.yellow <= ctrl_en_q && yel_d;
      end
   end

   assign err_out = err_q;

endmodule : sls_led_seq

// File: inc/sls_pkg.sv
package sls_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ      = 250;
   localparam int TICK_US      = 1000;                 // Pattern time base: 1 ms
   localparam int TICK_CYC     = TICK_US * CLK_MHZ;    // 250000 cycles
   localparam int FRAME_MS     = 1000;                 // Yellow pattern length
   localparam int HALF_MS      = 500;                  // Fade ramp / hold / slow blink
   localparam int FAST_MS      = 125;                  // 8 blinks per second
   localparam int FAST_ON_MS   = 62;
   localparam int SLOT_MS      = 200;                  // Blink group slot
   localparam int SLOT_ON_MS   = 100;
   localparam int BOOT_FRAME_MS = 1400;                // Bootloader double blink
   localparam int SUSP_ON_MS   = 20;                   // Suspend heartbeat pulse
   localparam int FLICK_MS     = 50;                   // Activity / command blink
   localparam int PWM_STEPS    = 250;                  // Duty steps per ramp

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0]  CTRL_OFS    = 4'h0;
   localparam logic [3:0]  STATUS_OFS  = 4'h4;
   localparam logic [3:0]  FRAME_OFS   = 4'h8;
   localparam int          CTRL_EN_BIT = 0;
   localparam logic        CTRL_EN_RST = 1'b1;
   localparam int          ST_BUSY_BIT = 16;
   localparam int          ST_LED_LSB  = 17;

   // ------------------------------------------------------------
   // Yellow patterns
   // ------------------------------------------------------------
   typedef enum logic [10:0] {
      Y_OFF        = 11'h001,
      Y_SOLID      = 11'h002,
      Y_FADE_UP    = 11'h004,
      Y_FADE_DN    = 11'h008,
      Y_ON_BLINK2  = 11'h010,
      Y_ON_BLINK1  = 11'h020,
      Y_FAST8      = 11'h040,
      Y_SLOW       = 11'h080,
      Y_OFF_BLINK3 = 11'h100,
      Y_OFF_BLINK2 = 11'h200,
      Y_OFF_BLINK1 = 11'h400
   } sls_ypat_t;

   // Internal status inputs of the controller
   typedef struct packed {
      logic usb_configured;     // Host recognized the device
      logic usb_activity;       // Pulse per USB transaction
      logic usb_suspend;
      logic usb_power_only;     // Board powered from USB alone
      logic err_active;
      logic safe_start_only;    // Safe-start violation is the only error
      logic coils_energized;    // From driver drive signals, not motor feedback
      logic vel_pos;
      logic vel_neg;
      logic driver_fault;       // Overcurrent or overtemperature
      logic motor_supply_input_low;
      logic coil_release_cmd;   // Coils released by explicit command
      logic boot_mode;
      logic boot_recognized;
      logic usb_cmd_rx;         // Pulse per USB command in bootloader
      logic app_image_present;
   } sls_status_t;

   typedef struct packed {
      logic green;
      logic red;
      logic yellow;
   } sls_leds_t;

endpackage : sls_pkg

// File: tb/sls_led_viewer.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Indicator viewer: counts yellow and green turn-ons and lit cycles
// ------------------------------------------------------------
module sls_led_viewer
  import sls_pkg::*;
(
   input  wire logic             clk,
   input  wire sls_pkg::sls_leds_t leds,
   input  wire logic             clr,
   output logic [15:0]           y_rise,
   output logic [15:0]           y_on,
   output logic [15:0]           g_rise,
   output logic [15:0]           g_on
);
   sls_leds_t prev_q;

   // An eye sees only levels, so edges are counted against the last cycle
   always_ff @(posedge clk) begin
      prev_q <= leds;
      if (clr) begin
         y_rise <= '0;
         y_on   <= '0;
         g_rise <= '0;
         g_on   <= '0;
      end else begin
         y_rise <= y_rise + 16'(leds.yellow & !prev_q.yellow);
         y_on   <= y_on + 16'(leds.yellow);
         g_rise <= g_rise + 16'(leds.green & !prev_q.green);
         g_on   <= g_on + 16'(leds.green);
      end
   end
endmodule : sls_led_viewer

// File: tb/sls_led_seq_sva.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module sls_led_seq_chk
  import sls_pkg::*;
#(
   parameter int TICK_CYCLES = 10
)(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire sls_pkg::sls_status_t sts,
   input  wire sls_pkg::sls_leds_t leds,
   input  wire logic               err_out,
   input  wire logic               startup_busy,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic               avs_waitrequest
);
   localparam int BUSY_MAX = 1000 * TICK_CYCLES + 8;
   localparam int SUS_MAX  = 20 * TICK_CYCLES + 4;
   int busy_q;
   int sus_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Run lengths; long spans are counted, not unrolled
   always_ff @(posedge clk) begin
      busy_q <= (!rst_n || !startup_busy) ? 0 : busy_q + 1;
   end
   always_ff @(posedge clk) begin
      sus_q <= (!rst_n || !(sts.usb_suspend && sts.usb_power_only && leds.green)) ? 0 : sus_q + 1;
   end

   property p_red_err;
      leds.red == err_out;
   endproperty
   a_red_err: assert property (p_red_err) else $error("red lamp differs from error pin");

   property p_err_red;
      !sts.boot_mode && !startup_busy && sts.err_active |=> leds.red;
   endproperty
   a_err_red: assert property (p_err_red) else $error("red dark during error");

   property p_flick;
      sts.usb_activity && sts.usb_configured && !sts.usb_suspend && !sts.boot_mode
         && !startup_busy |=> ##1 !leds.green [*8];
   endproperty
   a_flick: assert property (p_flick) else $error("no green flicker on traffic");

   property p_boot_red;
      sts.boot_mode ##1 sts.boot_mode |-> leds.red == !$past(sts.app_image_present);
   endproperty
   a_boot_red: assert property (p_boot_red) else $error("bootloader red wrong");

   property p_start_red;
      startup_busy && !sts.boot_mode ##1 startup_busy |-> leds.red;
   endproperty
   a_start_red: assert property (p_start_red) else $error("red dark in startup");

   property p_busy_len;
      busy_q <= BUSY_MAX;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("startup blinking too long");

   property p_sus;
      sus_q <= SUS_MAX;
   endproperty
   a_sus: assert property (p_sus) else $error("suspend pulse too long");

   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("more than one wait state");

   c_start: cover property ($fell(startup_busy));
   c_flick: cover property (sts.usb_activity && sts.usb_configured);
   c_boot:  cover property (sts.boot_mode && leds.red);
endmodule : sls_led_seq_chk

bind sls_led_seq sls_led_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clk(clk), .rst_n(rst_n), .sts(sts), .leds(leds), .err_out(err_out),
   .startup_busy(startup_busy), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest));

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench
  import sls_pkg::*;
;
   localparam int T = 2;
   localparam int F = 1000 * T;
   logic clk, rst_n, ce, rst_ab, clr, rd_q, wr_q, wreq;
   sls_status_t sts;
   sls_leds_t leds;
   logic err_out, busy;
   logic [3:0] adr;
   logic [31:0] wdat, rdat, d;
   logic [15:0] yr, yo, gr, go;
   int miscompares = 0;
   int tests_run = 0;
   sls_ypat_t cur = Y_OFF;

   sls_led_seq #(.TICK_CYCLES(T)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .sts(sts),
      .reset_abnormal(rst_ab), .leds(leds), .err_out(err_out), .startup_busy(busy),
      .avs_address(adr), .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wdat),
      .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq));
   sls_led_viewer u_view (.clk(clk), .leds(leds), .clr(clr), .y_rise(yr), .y_on(yo),
      .g_rise(gr), .g_on(go));

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task end_sim;
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk

   function logic near(input logic [15:0] s, input int e, input int t);
      return (s >= e - t) && (s <= e + t);
   endfunction : near

   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      adr  <= a;
      wdat <= v;
      rd_q <= !w;
      wr_q <= w;
      do @(posedge clk); while (wreq !== 1'b0);
      d = rdat;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
   endtask : bus

   // Window of n cycles on the viewer; pm pulses status bits once
   task meas(input int n, input logic [15:0] pm);
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) begin
         clr <= 1'b0;
         sts <= sls_status_t'(sts | pm);
      end
      @(posedge clk) sts <= sls_status_t'(sts & ~pm);
      repeat (n) @(posedge clk);
   endtask : meas

   // Select a yellow pattern, wait for it, then watch one full frame
   task ycase(input logic [15:0] s, input sls_ypat_t p, input int r, input int on, input int t);
      int n;
      logic [31:0] f;
      sts <= sls_status_t'(s);
      bus(1'b0, 4'h8, 0);
      f = d;
      bus(1'b0, 4'h4, 0);
      if (f[9:0] < 10'd900) chk("hold", d[10:0], cur);
      n = 0;
      do begin
         bus(1'b0, 4'h4, 0);
         n++;
      end while (d[10:0] !== p && n < 3000);
      chk("ypat", d[10:0], p);
      cur = p;
      meas(F, 16'h0);
      if (r >= 0) chk("yrise", yr, r);
      chk("yon", near(yo, on, t), 1'b1);
   endtask : ycase

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Whole run is about 30 frames; a hang stops well past that
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   initial begin
      rst_n = 1'b0; ce = 1'b1; rst_ab = 1'b1; clr = 1'b1; sts = '0;
      adr = '0; rd_q = 1'b0; wr_q = 1'b0; wdat = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      clr   <= 1'b0;
      bus(1'b0, 4'h4, 0);
      chk("busy", d[16], 1'b1);
      chk("red", d[18], 1'b1);
      repeat (F - 40) @(posedge clk);
      chk("start_blinks", yr, 16'd8);
      repeat (60) @(posedge clk);
      chk("busy_end", busy, 1'b0);
      bus(1'b0, 4'h0, 0);
      chk("ctrl_rst", d, 32'h1);
      bus(1'b0, 4'hc, 0);
      chk("unmapped", d, 32'h0);
      ycase(16'h8200, Y_SOLID, 0, F, 8);
      bus(1'b1, 4'h4, 32'h0);
      bus(1'b0, 4'h4, 0);
      chk("ro_status", d[10:0], Y_SOLID);
      bus(1'b1, 4'h0, 32'h0);
      repeat (2) @(posedge clk);
      chk("blank", leds.yellow, 1'b0);
      bus(1'b1, 4'h0, 32'h1);
      ycase(16'h8300, Y_FADE_UP, -1, 1500, 80);
      ycase(16'h8280, Y_FADE_DN, -1, 1500, 80);
      ycase(16'h8a00, Y_ON_BLINK2, 2, 1600, 8);
      ycase(16'h8e00, Y_ON_BLINK1, 1, 1800, 8);
      ycase(16'h8040, Y_FAST8, 8, 992, 20);
      ycase(16'h8020, Y_SLOW, 1, 1000, 8);
      ycase(16'h8010, Y_OFF_BLINK3, 3, 600, 8);
      ycase(16'h8800, Y_OFF_BLINK2, 2, 400, 8);
      ycase(16'h8c00, Y_OFF_BLINK1, 1, 200, 8);
      ycase(16'h8000, Y_OFF, 0, 0, 0);
      meas(F, 16'h4000);
      chk("g_flick", near(go, F - 100, 8), 1'b1);
      sts <= '0;
      meas(F, 16'h0);
      chk("g_slow", near(go, 1000, 8), 1'b1);
      chk("g_slow_n", gr, 16'd1);
      sts <= sls_status_t'(16'h3000);
      meas(F, 16'h0);
      chk("g_susp", near(go, 20 * T, 4), 1'b1);
      chk("g_susp_n", gr, 16'd1);
      sts <= sls_status_t'(16'h000c);
      repeat (2 * F) @(posedge clk);
      bus(1'b0, 4'h4, 0);
      chk("boot_red", d[18], 1'b1);
      meas(1400 * T, 16'h0002);
      chk("boot_g_n", gr, 16'd2);
      chk("boot_g_on", near(go, 200 * T, 8), 1'b1);
      chk("boot_y", near(yo, 1350 * T, 8), 1'b1);
      sts <= sls_status_t'(16'h000d);
      repeat (3) @(posedge clk);
      chk("boot_red_off", leds.red, 1'b0);
      end_sim();
   end
endmodule : testbench
